/* File: rtl/eci_consts.svh */
`ifndef ECI_CONSTS_SVH
`define ECI_CONSTS_SVH

// ==========================================================
// register byte offsets
`define ECI_OFS_CTRL 8'h00
`define ECI_OFS_STATUS 8'h04
`define ECI_OFS_IRQ_STAT 8'h08
`define ECI_OFS_IRQ_MASK 8'h0C
`define ECI_OFS_PERIOD 8'h10
`define ECI_OFS_SEQ_SYNC 8'h14
`define ECI_OFS_SW_CMD 8'h18

// ==========================================================
// control register fields
`define ECI_CTRL_SRC_BIT 0
`define ECI_CTRL_MODE_LO 1
`define ECI_CTRL_MODE_HI 2
`define ECI_CTRL_BUSY_BIT 3
`define ECI_CTRL_RESET 32'h0000_0000

// ==========================================================
// command channel indices (pin order off, on, start, stop, hold, br1, br2)
`define ECI_NUM_CMD 7
`define ECI_CMD_OFF 0
`define ECI_CMD_ON 1
`define ECI_CMD_START 2
`define ECI_CMD_STOP 3
`define ECI_CMD_HOLD 4
`define ECI_CMD_BR1 5
`define ECI_CMD_BR2 6

// ==========================================================
// interrupt status bits above the seven command bits
`define ECI_IRQ_LOCK_GAIN 7
`define ECI_IRQ_LOCK_LOSS 8
`define ECI_IRQ_LIMIT 9
`define ECI_NUM_IRQ 10

// ==========================================================
// timing
`define ECI_CLK_HZ 50000000
`define ECI_DEBOUNCE_NS 1000
`define ECI_DEBOUNCE_CYC ((`ECI_DEBOUNCE_NS * 50 + 999) / 1000)
`define ECI_LOCK_LO_DHZ 400
`define ECI_LOCK_HI_DHZ 9999
`define ECI_PERIOD_MAX_CYC ((`ECI_CLK_HZ * 10) / `ECI_LOCK_LO_DHZ)
`define ECI_PERIOD_MIN_CYC ((`ECI_CLK_HZ * 10 + `ECI_LOCK_HI_DHZ - 1) / `ECI_LOCK_HI_DHZ)
`define ECI_PERIOD_W 21

`endif

/* File: rtl/eci_pkg.sv */
// ==========================================================
// shared types
package eci_pkg;
  typedef enum logic [1:0] {
    ECI_SEQ_IDLE,
    ECI_SEQ_RUN,
    ECI_SEQ_HOLD
  } eci_seq_t;

  // output mode field of the control register
  typedef enum logic [1:0] {
    ECI_MODE_FREE,
    ECI_MODE_ALTERNATING_SYNC,
    ECI_MODE_COMBINED_SYNC
  } eci_mode_t;
endpackage

/* File: rtl/eci_cmd_if.sv */
`timescale 1ns/10ps
`include "eci_consts.svh"

// ==========================================================
// filtered command pulses from the pin filter to the core
interface eci_cmd_if;
  logic [`ECI_NUM_CMD-1:0] cmd_pulse;
  modport src (output cmd_pulse);
  modport dst (input cmd_pulse);
endinterface

/* File: rtl/eci_cmd_filter.sv */
`timescale 1ns/10ps
`include "eci_consts.svh"

module eci_cmd_filter #(
  parameter int N = `ECI_NUM_CMD,
  parameter int DEB_CYC = `ECI_DEBOUNCE_CYC
) (
  input wire logic clk_i, // system clock
  input wire logic rst_i, // synchronous reset, high
  input wire logic [N-1:0] cmd_n_i, // raw active-low command pins
  eci_cmd_if.src cmd // filtered pulses
);
  localparam int CW = $clog2(DEB_CYC + 1);

  logic [N-1:0] meta_r;
  logic [N-1:0] sync_r;
  logic [N-1:0] stable_r;
  logic [N-1:0] pulse_r;
  logic [CW-1:0] cnt_r [N];

  // ==========================================================
  // two-stage synchroniser, idle high so a floating pin stays quiet
  // two flop synchroniser
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      meta_r <= '1;
      sync_r <= '1;
    end else begin
      meta_r <= cmd_n_i;
      sync_r <= meta_r;
    end
  end

  // ==========================================================
  // debounce: level must differ for DEB_CYC cycles before it is taken
  // debounce then edge
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      stable_r <= '1;
      pulse_r <= '0;
      for (int i = 0; i < N; i++) begin
        cnt_r[i] <= '0;
      end
    end else begin
      for (int i = 0; i < N; i++) begin
        pulse_r[i] <= 1'b0;
        if (sync_r[i] == stable_r[i]) begin
          cnt_r[i] <= '0;
        end else if (cnt_r[i] == CW'(DEB_CYC - 1)) begin
          cnt_r[i] <= '0;
          stable_r[i] <= sync_r[i];
          // only the high-to-low change yields a command
          pulse_r[i] <= stable_r[i];
        end else begin
          cnt_r[i] <= cnt_r[i] + 1'b1;
        end
      end
    end
  end

  assign cmd.cmd_pulse = pulse_r;
endmodule

/* File: rtl/eci_top.sv */
// Operation
// - power, output and busy status, high active
// - limiter output on any limiter acting
// - two sequence sync outputs from sequencer
// - commands act on falling input edge
// - sync modes lock to the selected reference
// - no phase offset in sync modes
// - sync source selects external or line
// - line source follows incoming mains frequency
`timescale 1ns/10ps
`include "eci_consts.svh"

module eci_top #(
  parameter int DEB_CYC = `ECI_DEBOUNCE_CYC,
  parameter int PERIOD_MIN = `ECI_PERIOD_MIN_CYC,
  parameter int PERIOD_MAX = `ECI_PERIOD_MAX_CYC
) (
  input wire logic clk_i, // system clock, 50 MHz
  input wire logic rst_i, // synchronous reset, high
  // ahb-lite slave
  input wire logic hsel_i, // slave select
  input wire logic [7:0] haddr_i, // byte address
  input wire logic [1:0] htrans_i, // transfer type
  input wire logic hwrite_i, // write when high
  input wire logic [2:0] hsize_i, // transfer size
  input wire logic [31:0] hwdata_i, // write data
  input wire logic hready_i, // bus ready
  output logic hreadyout_o, // slave ready
  output logic hresp_o, // response, always okay
  output logic [31:0] hrdata_o, // read data
  // command pins, active low
  input wire logic [`ECI_NUM_CMD-1:0] cmd_n_i, // off, on, start, stop, hold, br1, br2
  // references, asynchronous pins
  input wire logic external_reference_i, // external ttl sync reference
  input wire logic line_ref_i, // mains zero-cross square wave
  // source state, same clock domain
  input wire logic power_on_i, // main power is on
  input wire logic lim_pos_pk_i, // positive peak limiter acting
  input wire logic lim_neg_pk_i, // negative peak limiter acting
  input wire logic lim_avg_i, // average current limiter acting
  input wire logic lim_pwr_i, // power limiter acting
  // status pins
  output logic power_on_o, // main power status
  output logic output_on_o, // output enabled status
  output logic limiter_active_status_o, // any limiter acting
  output logic busy_o, // firmware busy
  output logic seq_sync0_o, // sequence sync 0
  output logic seq_sync1_o, // sequence sync 1
  // to the oscillator
  output logic osc_sync_o, // one-cycle pulse at reference rising edge
  output logic locked_o, // reference within lock range, sync mode on
  output logic irq_o // level interrupt
);
  // ==========================================================
  // declarations
  eci_cmd_if cmd_bus ();

  logic [31:0] ctrl_r;
  logic [`ECI_NUM_IRQ-1:0] irq_stat_r;
  logic [`ECI_NUM_IRQ-1:0] irq_mask_r;
  logic [1:0] seq_sync_r;
  logic [`ECI_PERIOD_W-1:0] period_cnt_r;
  logic [`ECI_PERIOD_W-1:0] period_r;
  logic ttl_meta_r, ttl_sync_r, line_meta_r, line_sync_r;
  logic ref_prev_r;
  logic seen_edge_r;
  logic in_range_r;
  logic lim_prev_r;
  eci_pkg::eci_seq_t seq_r;
  eci_pkg::eci_seq_t seq_nxt;
  // ahb data phase
  logic dp_wr_r;
  logic [7:0] dp_addr_r;
  logic sw_on_pulse_r, sw_off_pulse_r;

  logic addr_ph;
  logic [`ECI_NUM_CMD-1:0] cmd_p;
  logic ref_sel;
  logic ref_rise;
  logic sync_mode;
  logic lim_now;
  logic lock_now;
  logic [`ECI_NUM_IRQ-1:0] irq_evt;
  logic rd_irq;

  // ==========================================================
  // helpers
  function automatic logic reg_hit(input logic [7:0] a, input logic [7:0] ofs);
    reg_hit = (a[7:2] == ofs[7:2]);
  endfunction

  function automatic logic [31:0] zext_irq(input logic [`ECI_NUM_IRQ-1:0] v);
    zext_irq = {{(32 - `ECI_NUM_IRQ){1'b0}}, v};
  endfunction

  // ==========================================================
  // command pin filter
  eci_cmd_filter #(
    .N(`ECI_NUM_CMD),
    .DEB_CYC(DEB_CYC)
  ) u_filter (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .cmd_n_i(cmd_n_i),
    .cmd(cmd_bus.src)
  );

  assign cmd_p = cmd_bus.cmd_pulse;

  // ==========================================================
  // ahb-lite slave: zero wait states, always okay
  assign addr_ph = hsel_i && htrans_i[1] && hready_i;
  assign rd_irq = addr_ph && !hwrite_i && reg_hit(haddr_i, `ECI_OFS_IRQ_STAT);

  // address phase capture; write data lands in the following cycle
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      dp_wr_r <= 1'b0;
      dp_addr_r <= 8'h00;
    end else begin
      dp_wr_r <= addr_ph && hwrite_i;
      dp_addr_r <= haddr_i;
    end
  end

  // handshake flops; this slave never stretches a transfer
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      hreadyout_o <= 1'b1;
      hresp_o <= 1'b0;
    end else begin
      hreadyout_o <= 1'b1;
      hresp_o <= 1'b0;
    end
  end

  // read data is prepared in the address phase so hrdata comes from a flop
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      hrdata_o <= 32'h0000_0000;
    end else if (addr_ph && !hwrite_i) begin
      if (reg_hit(haddr_i, `ECI_OFS_CTRL)) begin
        hrdata_o <= {28'h000_0000, ctrl_r[3:0]};
      end else if (reg_hit(haddr_i, `ECI_OFS_STATUS)) begin
        hrdata_o <= {25'h000_0000, seq_r, locked_o, limiter_active_status_o,
                     busy_o, output_on_o, power_on_o};
      end else if (reg_hit(haddr_i, `ECI_OFS_IRQ_STAT)) begin
        hrdata_o <= zext_irq(irq_stat_r);
      end else if (reg_hit(haddr_i, `ECI_OFS_IRQ_MASK)) begin
        hrdata_o <= zext_irq(irq_mask_r);
      end else if (reg_hit(haddr_i, `ECI_OFS_PERIOD)) begin
        hrdata_o <= {{(32 - `ECI_PERIOD_W){1'b0}}, period_r};
      end else if (reg_hit(haddr_i, `ECI_OFS_SEQ_SYNC)) begin
        hrdata_o <= {30'h0000_0000, seq_sync_r};
      end else begin
        // unmapped and write-only addresses read as zero
        hrdata_o <= 32'h0000_0000;
      end
    end
  end

  // control and sequence-sync registers
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl_r <= `ECI_CTRL_RESET;
      seq_sync_r <= 2'b00;
      irq_mask_r <= '0;
    end else if (dp_wr_r) begin
      if (reg_hit(dp_addr_r, `ECI_OFS_CTRL)) begin
        ctrl_r <= {28'h000_0000, hwdata_i[3:0]};
      end else if (reg_hit(dp_addr_r, `ECI_OFS_SEQ_SYNC)) begin
        seq_sync_r <= hwdata_i[1:0];
      end else if (reg_hit(dp_addr_r, `ECI_OFS_IRQ_MASK)) begin
        irq_mask_r <= hwdata_i[`ECI_NUM_IRQ-1:0];
      end
    end
  end

  // software output on/off, one-cycle pulses from a write to SW_CMD
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sw_on_pulse_r <= 1'b0;
      sw_off_pulse_r <= 1'b0;
    end else begin
      sw_on_pulse_r <= dp_wr_r && reg_hit(dp_addr_r, `ECI_OFS_SW_CMD) && hwdata_i[0];
      sw_off_pulse_r <= dp_wr_r && reg_hit(dp_addr_r, `ECI_OFS_SW_CMD) && hwdata_i[1];
    end
  end

  // ==========================================================
  // status outputs
  // any limiter acting
  assign lim_now = lim_pos_pk_i | lim_neg_pk_i | lim_avg_i | lim_pwr_i;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      power_on_o <= 1'b0;
      busy_o <= 1'b0;
      limiter_active_status_o <= 1'b0;
      lim_prev_r <= 1'b0;
    end else begin
      power_on_o <= power_on_i;
      busy_o <= ctrl_r[`ECI_CTRL_BUSY_BIT];
      limiter_active_status_o <= lim_now;
      lim_prev_r <= lim_now;
    end
  end

  // output enable: off wins when both arrive together, the safe choice
  // on and off commands
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      output_on_o <= 1'b0;
    end else if (cmd_p[`ECI_CMD_OFF] || sw_off_pulse_r || !power_on_i) begin
      output_on_o <= 1'b0;
    end else if (cmd_p[`ECI_CMD_ON] || sw_on_pulse_r) begin
      output_on_o <= 1'b1;
    end
  end

  // ==========================================================
  // sequencer run state; stop outranks hold in run and start in hold
  always_comb begin
    seq_nxt = seq_r;
    case (seq_r)
      eci_pkg::ECI_SEQ_IDLE: begin
        if (cmd_p[`ECI_CMD_START]) begin
          seq_nxt = eci_pkg::ECI_SEQ_RUN;
        end
      end
      eci_pkg::ECI_SEQ_RUN: begin
        if (cmd_p[`ECI_CMD_STOP]) begin
          seq_nxt = eci_pkg::ECI_SEQ_IDLE;
        end else if (cmd_p[`ECI_CMD_HOLD]) begin
          seq_nxt = eci_pkg::ECI_SEQ_HOLD;
        end
      end
      eci_pkg::ECI_SEQ_HOLD: begin
        if (cmd_p[`ECI_CMD_STOP]) begin
          seq_nxt = eci_pkg::ECI_SEQ_IDLE;
        end else if (cmd_p[`ECI_CMD_START]) begin
          seq_nxt = eci_pkg::ECI_SEQ_RUN;
        end
      end
      default: begin
        seq_nxt = eci_pkg::ECI_SEQ_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      seq_r <= eci_pkg::ECI_SEQ_IDLE;
    end else begin
      seq_r <= seq_nxt;
    end
  end

  // sync outputs follow firmware pattern only while a sequence is active
  // two sync outputs
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      seq_sync0_o <= 1'b0;
      seq_sync1_o <= 1'b0;
    end else begin
      seq_sync0_o <= seq_sync_r[0] && (seq_nxt != eci_pkg::ECI_SEQ_IDLE);
      seq_sync1_o <= seq_sync_r[1] && (seq_nxt != eci_pkg::ECI_SEQ_IDLE);
    end
  end

  // ==========================================================
  // reference synchronisers
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ttl_meta_r <= 1'b0;
      ttl_sync_r <= 1'b0;
      line_meta_r <= 1'b0;
      line_sync_r <= 1'b0;
    end else begin
      ttl_meta_r <= external_reference_i;
      ttl_sync_r <= ttl_meta_r;
      line_meta_r <= line_ref_i;
      line_sync_r <= line_meta_r;
    end
  end

  assign ref_sel = ctrl_r[`ECI_CTRL_SRC_BIT] ? line_sync_r : ttl_sync_r;
  assign ref_rise = ref_sel && !ref_prev_r;
  assign sync_mode = (ctrl_r[`ECI_CTRL_MODE_HI:`ECI_CTRL_MODE_LO] == eci_pkg::ECI_MODE_ALTERNATING_SYNC) ||
                     (ctrl_r[`ECI_CTRL_MODE_HI:`ECI_CTRL_MODE_LO] == eci_pkg::ECI_MODE_COMBINED_SYNC);

  // period measurement; counter saturates so a dead reference drops lock
  // measure reference period
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ref_prev_r <= 1'b0;
      period_cnt_r <= '0;
      period_r <= '0;
      seen_edge_r <= 1'b0;
    end else begin
      ref_prev_r <= ref_sel;
      if (ref_rise) begin
        period_cnt_r <= `ECI_PERIOD_W'(1);
        seen_edge_r <= 1'b1;
        if (seen_edge_r) begin
          period_r <= period_cnt_r;
        end
      end else if (period_cnt_r != '1) begin
        period_cnt_r <= period_cnt_r + 1'b1;
      end
    end
  end

  assign lock_now = sync_mode && in_range_r &&
                    (period_cnt_r <= `ECI_PERIOD_W'(PERIOD_MAX));

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      in_range_r <= 1'b0;
      locked_o <= 1'b0;
    end else begin
      in_range_r <= (period_r >= `ECI_PERIOD_W'(PERIOD_MIN)) &&
                    (period_r <= `ECI_PERIOD_W'(PERIOD_MAX)) && (period_r != '0);
      locked_o <= lock_now;
    end
  end

  // oscillator restart strobe sits on the reference edge itself: there is
  // deliberately no offset register, so the phase cannot be moved
  // zero phase offset
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      osc_sync_o <= 1'b0;
    end else begin
      osc_sync_o <= ref_rise && lock_now;
    end
  end

  // ==========================================================
  // interrupts: sticky, cleared by reading, a new event wins over the clear
  assign irq_evt = {lim_now && !lim_prev_r, locked_o && !lock_now,
                    !locked_o && lock_now, cmd_p};

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_stat_r <= '0;
    end else if (rd_irq) begin
      irq_stat_r <= irq_evt;
    end else begin
      irq_stat_r <= irq_stat_r | irq_evt;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_o <= 1'b0;
    end else begin
      irq_o <= |(irq_stat_r & irq_mask_r);
    end
  end

endmodule

/* File: sim/eci_top_chk.sv */
`timescale 1ns/10ps
`include "eci_consts.svh"

// ==========================================================
// port-level checks of the external control block
module eci_top_chk #(
  parameter int DEB_CYC = 3
) (
  input wire logic clk_i, // system clock
  input wire logic rst_i, // synchronous reset, high
  input wire logic hsel_i, // slave select
  input wire logic [1:0] htrans_i, // transfer type
  input wire logic hwrite_i, // write when high
  input wire logic hready_i, // bus ready
  input wire logic hreadyout_o, // slave ready
  input wire logic hresp_o, // response
  input wire logic [`ECI_NUM_CMD-1:0] cmd_n_i, // command pins
  input wire logic power_on_i, // main power
  input wire logic lim_pos_pk_i, // positive peak limiter
  input wire logic lim_neg_pk_i, // negative peak limiter
  input wire logic lim_avg_i, // average limiter
  input wire logic lim_pwr_i, // power limiter
  input wire logic power_on_o, // power status
  input wire logic output_on_o, // output status
  input wire logic limiter_active_status_o, // limiter status
  input wire logic busy_o, // busy status
  input wire logic seq_sync0_o, // sequence sync 0
  input wire logic seq_sync1_o, // sequence sync 1
  input wire logic osc_sync_o, // oscillator sync pulse
  input wire logic locked_o // reference locked
);
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  // history of taken writes; busy may only move a few cycles after one
  logic [2:0] wr_q_r;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wr_q_r <= 3'h0;
    end else begin
      wr_q_r <= {wr_q_r[1:0], hsel_i & htrans_i[1] & hready_i & hwrite_i};
    end
  end

  // stop pin held low past the filter time
  sequence s_stop_held;
    $fell(cmd_n_i[`ECI_CMD_STOP]) ##1 !cmd_n_i[`ECI_CMD_STOP] [*8];
  endsequence

  property p_pwr_copy;
    !$past(rst_i) |-> power_on_o == $past(power_on_i);
  endproperty
  a_pwr_copy: assert property (p_pwr_copy) else $error("power status does not follow input");
  property p_off_on_loss;
    !power_on_i |=> !output_on_o;
  endproperty
  a_off_on_loss: assert property (p_off_on_loss) else $error("output stays on without power");
  property p_busy_by_write;
    $changed(busy_o) |-> (|wr_q_r);
  endproperty
  a_busy_by_write: assert property (p_busy_by_write) else $error("busy moved without a write");
  property p_lim_or;
    !$past(rst_i) |-> limiter_active_status_o == $past(lim_pos_pk_i | lim_neg_pk_i | lim_avg_i | lim_pwr_i);
  endproperty
  a_lim_or: assert property (p_lim_or) else $error("limiter status wrong");
  property p_seq_stop;
    s_stop_held |=> !seq_sync0_o && !seq_sync1_o;
  endproperty
  a_seq_stop: assert property (p_seq_stop) else $error("sync outputs alive after stop");
  // idle pin commands nothing, only a write may
  property p_on_idle;
    cmd_n_i[`ECI_CMD_ON] [*8] |=> !$rose(output_on_o) || wr_q_r[2];
  endproperty
  a_on_idle: assert property (p_on_idle) else $error("output rose without on command");
  property p_osc_lock;
    osc_sync_o |-> locked_o || $past(locked_o);
  endproperty
  a_osc_lock: assert property (p_osc_lock) else $error("sync pulse while unlocked");
  property p_osc_pulse;
    osc_sync_o |=> !osc_sync_o;
  endproperty
  a_osc_pulse: assert property (p_osc_pulse) else $error("sync pulse too long");
  property p_bus_ok;
    hreadyout_o && !hresp_o;
  endproperty
  a_bus_ok: assert property (p_bus_ok) else $error("bus not ready or error response");
endmodule

bind eci_top eci_top_chk #(.DEB_CYC(DEB_CYC)) u_chk (.*);

/* File: sim/eci_ctl_model.sv */
`timescale 1ns/10ps
`include "eci_consts.svh"

// ==========================================================
// outside logic controller and reference sources
module eci_ctl_model #(
  parameter int DEB_CYC = 3
) (
  input wire logic clk_i, // system clock
  output logic [`ECI_NUM_CMD-1:0] cmd_n_o, // command pins, active low
  output logic external_reference_o, // external reference
  output logic line_ref_o // mains square wave
);
  int ttl_per = 0;
  int line_per = 0;
  int ttl_cnt = 0;
  int line_cnt = 0;

  // pins rest high as the pull-up holds them
  initial begin
    cmd_n_o = '1;
    external_reference_o = 1'b0;
    line_ref_o = 1'b0;
  end

  task automatic press(input int idx, input int n);
    @(posedge clk_i);
    cmd_n_o[idx] <= 1'b0;
    repeat (n) @(posedge clk_i);
    cmd_n_o[idx] <= 1'b1;
    // stay released long enough before any next command
    repeat (DEB_CYC + 4) @(posedge clk_i);
  endtask

  // square references; a period of zero parks the line low
  always @(posedge clk_i) begin
    ttl_cnt <= (ttl_per == 0 || ttl_cnt >= ttl_per - 1) ? 0 : ttl_cnt + 1;
    external_reference_o <= (ttl_per != 0) && (ttl_cnt < ttl_per / 2);
    line_cnt <= (line_per == 0 || line_cnt >= line_per - 1) ? 0 : line_cnt + 1;
    line_ref_o <= (line_per != 0) && (line_cnt < line_per / 2);
  end
endmodule

/* File: sim/external_control_io_tb_top.sv */
`timescale 1ns/10ps
`include "eci_consts.svh"

module external_control_io_tb_top;
  localparam int DEB = 3;
  logic clk_i = 0;
  logic rst_i = 1;
  logic hsel_i = 0;
  logic hwrite_i = 0;
  logic [7:0] haddr_i = 8'h00;
  logic [1:0] htrans_i = 2'h0;
  logic [2:0] hsize_i = 3'h2;
  logic [31:0] hwdata_i = 32'h0000_0000;
  logic power_on_i = 1;
  logic [3:0] lim4 = 4'h0;
  logic lim_pos_pk_i, lim_neg_pk_i, lim_avg_i, lim_pwr_i, hready_i;
  logic [`ECI_NUM_CMD-1:0] cmd_n_i;
  logic external_reference_i, line_ref_i, hreadyout_o, hresp_o, power_on_o, output_on_o;
  logic limiter_active_status_o, busy_o, seq_sync0_o, seq_sync1_o, osc_sync_o, locked_o, irq_o;
  logic [31:0] hrdata_o, q, r;
  logic [31:0] seed = 32'ha7fa186a;
  int mismatches = 0;
  int n_checks = 0;
  int cnt;
  int pers[5] = '{50, 20, 19, 200, 201};

  assign {lim_pos_pk_i, lim_neg_pk_i, lim_avg_i, lim_pwr_i} = lim4;
  // the one slave drives the bus ready
  assign hready_i = hreadyout_o;
  always #10 clk_i = ~clk_i;

  eci_top #(.DEB_CYC(DEB), .PERIOD_MIN(20), .PERIOD_MAX(200)) dut (.*);
  eci_ctl_model #(.DEB_CYC(DEB)) u_ctl (.clk_i(clk_i), .cmd_n_o(cmd_n_i), .external_reference_o(external_reference_i),
    .line_ref_o(line_ref_i));

  // ==========================================================
  // expectations and checks
  function logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  function logic [31:0] exp_irq(input int i);
    return 32'h0000_0001 << i;
  endfunction
  function logic exp_lim(input logic [3:0] v);
    return |v;
  endfunction
  task chk_bit(input logic got, input logic exp);
    n_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("MISMATCH %0t bit got %b exp %b", $time, got, exp);
    end
  endtask
  task chk_word(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("MISMATCH %0t word got %h exp %h", $time, got, exp);
    end
  endtask
  task tally_and_finish;
    if (mismatches == 0 && n_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  // ==========================================================
  // bounded waits and the bus master
  task automatic wait_for(input int sel, input logic v);
    int k;
    logic s;
    n_checks++;
    for (k = 0; k < 800; k++) begin
      @(posedge clk_i);
      s = (sel == 0) ? output_on_o : locked_o;
      if (s === v) break;
    end
    if (k == 800) begin
      mismatches++;
      $display("MISMATCH %0t wait timed out", $time);
      tally_and_finish();
    end
  endtask
  task automatic wait_rdy();
    int k;
    k = 0;
    do begin
      @(posedge clk_i);
      k++;
    end while (hreadyout_o !== 1'b1 && k < 20);
    if (hreadyout_o !== 1'b1) begin
      mismatches++;
      $display("MISMATCH %0t bus hang", $time);
      tally_and_finish();
    end
  endtask
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] rd);
    hsel_i <= 1'b1;
    haddr_i <= a;
    hwrite_i <= w;
    htrans_i <= 2'b10;
    wait_rdy();
    hsel_i <= 1'b0;
    htrans_i <= 2'b00;
    hwdata_i <= d;
    wait_rdy();
    rd = hrdata_o;
  endtask

  // ==========================================================
  // main sequence
  initial begin
    repeat (5) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    chk_bit(output_on_o, 1'b0);
    bus(1, `ECI_OFS_CTRL, 32'h0000_0008, q);
    bus(0, `ECI_OFS_CTRL, 32'h0000_0000, q);
    chk_word(q, 32'h0000_0008);
    repeat (2) @(posedge clk_i);
    chk_bit(busy_o, 1'b1);
    bus(1, `ECI_OFS_CTRL, 32'h0000_0000, q);
    bus(1, `ECI_OFS_PERIOD, 32'hffff_ffff, q);
    bus(0, `ECI_OFS_PERIOD, 32'h0000_0000, q);
    chk_word(q, 32'h0000_0000);
    bus(0, 8'h40, 32'h0000_0000, q);
    chk_word(q, 32'h0000_0000);
    repeat (2) @(posedge clk_i);
    chk_bit(busy_o, 1'b0);
    // random limiter and power levels
    for (int i = 0; i < 24; i++) begin
      r = xs();
      lim4 <= r[3:0];
      power_on_i <= r[4];
      repeat (2) @(posedge clk_i);
      chk_bit(limiter_active_status_o, exp_lim(lim4));
      chk_bit(power_on_o, power_on_i);
    end
    lim4 <= 4'h0;
    power_on_i <= 1'b1;
    bus(0, `ECI_OFS_IRQ_STAT, 32'h0000_0000, q);
    // every command pin, random hold time
    for (int i = 0; i < `ECI_NUM_CMD; i++) begin
      u_ctl.press(i, 9 + int'(xs() % 4));
      bus(0, `ECI_OFS_IRQ_STAT, 32'h0000_0000, q);
      chk_word(q, exp_irq(i));
    end
    chk_bit(output_on_o, 1'b1);
    u_ctl.press(`ECI_CMD_OFF, 1);
    chk_bit(output_on_o, 1'b1);
    bus(0, `ECI_OFS_IRQ_STAT, 32'h0000_0000, q);
    chk_word(q, 32'h0000_0000);
    power_on_i <= 1'b0;
    wait_for(0, 1'b0);
    power_on_i <= 1'b1;
    // interrupt masked, unmasked, cleared
    bus(1, `ECI_OFS_IRQ_MASK, exp_irq(`ECI_CMD_ON), q);
    bus(0, `ECI_OFS_IRQ_STAT, 32'h0000_0000, q);
    u_ctl.press(`ECI_CMD_OFF, 10);
    chk_bit(irq_o, 1'b0);
    u_ctl.press(`ECI_CMD_ON, 10);
    chk_bit(irq_o, 1'b1);
    chk_bit(output_on_o, 1'b1);
    bus(0, `ECI_OFS_IRQ_STAT, 32'h0000_0000, q);
    chk_word(q, exp_irq(`ECI_CMD_OFF) | exp_irq(`ECI_CMD_ON));
    repeat (3) @(posedge clk_i);
    chk_bit(irq_o, 1'b0);
    // sequence run, hold, resume, stop
    bus(1, `ECI_OFS_SEQ_SYNC, 32'h0000_0003, q);
    u_ctl.press(`ECI_CMD_START, 10);
    chk_bit(seq_sync0_o, 1'b1);
    chk_bit(seq_sync1_o, 1'b1);
    u_ctl.press(`ECI_CMD_HOLD, 10);
    chk_bit(seq_sync0_o, 1'b1);
    bus(0, `ECI_OFS_STATUS, 32'h0000_0000, q);
    chk_word(q, 32'h0000_0043);
    u_ctl.press(`ECI_CMD_START, 10);
    u_ctl.press(`ECI_CMD_STOP, 10);
    chk_bit(seq_sync0_o, 1'b0);
    chk_bit(seq_sync1_o, 1'b0);
    // software off, then software on
    bus(1, `ECI_OFS_SW_CMD, 32'h0000_0002, q);
    repeat (2) @(posedge clk_i);
    chk_bit(output_on_o, 1'b0);
    bus(1, `ECI_OFS_SW_CMD, 32'h0000_0001, q);
    repeat (2) @(posedge clk_i);
    chk_bit(output_on_o, 1'b1);
    // external reference across the lock range edges
    bus(1, `ECI_OFS_CTRL, 32'h0000_0002, q);
    u_ctl.line_per = 100;
    foreach (pers[i]) begin
      u_ctl.ttl_per = pers[i];
      repeat (700) @(posedge clk_i);
      chk_bit(locked_o, pers[i] >= 20 && pers[i] <= 200);
      bus(0, `ECI_OFS_PERIOD, 32'h0000_0000, q);
      chk_word(q, pers[i]);
    end
    u_ctl.ttl_per = 50;
    wait_for(1, 1'b1);
    cnt = 0;
    repeat (200) begin
      @(posedge clk_i);
      cnt += osc_sync_o;
    end
    chk_word(cnt, 32'h0000_0004);
    // line source follows the mains wave, not the external one
    bus(1, `ECI_OFS_CTRL, 32'h0000_0005, q);
    repeat (400) @(posedge clk_i);
    bus(0, `ECI_OFS_PERIOD, 32'h0000_0000, q);
    chk_word(q, 32'h0000_0064);
    chk_bit(locked_o, 1'b1);
    bus(1, `ECI_OFS_CTRL, 32'h0000_0001, q);
    wait_for(1, 1'b0);
    bus(0, `ECI_OFS_IRQ_STAT, 32'h0000_0000, q);
    chk_word(q, 32'h0000_019c);
    tally_and_finish();
  end
endmodule
